// File: rtl/mode_and_memory_map_control.sv
`default_nettype none
module mode_and_memory_map_control (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic modePinA,
   input wire logic modePinB,
   input wire logic [15:0] cpuAddr,
   input wire logic [7:0] cpuWrData,
   input wire logic cpuWr,
   input wire logic cpuRd,
   output logic [7:0] cpuRdData,
   input wire logic [7:0] intRdData,
   input wire logic intMaskSet,
   input wire logic [3:0] nvConfig,
   output mode_map_pkg::memSel_t memSel,
   output logic [15:0] mappedAddr,
   output mode_map_pkg::extBus_t extBus,
   output logic eClkPin,
   output logic bootRomEnable,
   output logic romEnable,
   output logic eepromEnable,
   output logic specialMode,
   output logic modeA,
   output logic [3:0] prioSelect,
   output logic [7:0] testCtl,
   output logic watchdogDisable,
   output logic securityDisable
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // True when an address lies in a block whose 4K page is pos
   function automatic logic inWindow(input logic [15:0] a,
                                     input logic [3:0] pos,
                                     input logic [11:0] spanMask);
      inWindow = (a[15:12] == pos) && ((a[11:0] & ~spanMask) == 12'h000);
   endfunction

   // True when an address selects one of our own registers
   function automatic logic ownReg(input logic [15:0] a,
                                   input logic [15:0] regAddr);
      ownReg = (a[5:0] == regAddr[5:0]);
   endfunction

   mode_map_pkg::mapState_t cur_ff, nxt_ff;
   logic access;
   logic [1:0] pinsNow;
   logic [15:0] effAddr;
   logic inRegs;
   logic [7:0] wd;

   assign access = cpuRd | cpuWr;
   assign wd = cpuWrData;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      nxt_ff = cur_ff;
      // Pin synchroniser: the first stage feeds only the second
      nxt_ff.pinS1 = {modePinB, modePinA};
      nxt_ff.pinS2 = cur_ff.pinS1;
      nxt_ff.pinS3 = cur_ff.pinS2;
      // Mode pins count only once stages two and three agree
      pinsNow = (cur_ff.pinS2 == cur_ff.pinS3) ? cur_ff.pinS3
                                               : cur_ff.modePins;
      // Vectors move down into the bootloader page in special modes
      effAddr = cpuAddr;
      if (cur_ff.specialMode && (cpuAddr >= mode_map_pkg::VEC_LO)) begin
         effAddr = {mode_map_pkg::VEC_ALT_LO[15:6], cpuAddr[5:0]};
      end
      inRegs = inWindow(cpuAddr, cur_ff.regPos,
                        mode_map_pkg::REG_SPAN_MASK);

      if (!rst_n) begin
         // Everything that depends on the mode is loaded from the pins
         nxt_ff.modePins = pinsNow;
         nxt_ff.bootMap = (pinsNow == mode_map_pkg::MODE_BOOT);
         nxt_ff.specialMode = ~pinsNow[1];
         nxt_ff.modeA = pinsNow[0];
         nxt_ff.rdVisE = (pinsNow == mode_map_pkg::MODE_TEST);
         nxt_ff.rdVisEWritten = 1'b0;
         nxt_ff.psel = mode_map_pkg::PSEL_RESET;
         nxt_ff.ramPos = mode_map_pkg::MAP_POS_RESET[7:4];
         nxt_ff.regPos = mode_map_pkg::MAP_POS_RESET[3:0];
         nxt_ff.mapWritten = 1'b0;
         nxt_ff.cycleCnt = 7'h00;
         nxt_ff.testCtl = 8'h00;
         // Disable bit fixed on the way out of a special reset
         nxt_ff.testCtl[mode_map_pkg::BIT_DISABLE_RST] = ~pinsNow[1];
         // Enables follow the nonvolatile copy; ROM is forced on in single-chip mode
         nxt_ff.memCfg = nvConfig;
         if (pinsNow == mode_map_pkg::MODE_SINGLE) begin
            nxt_ff.memCfg[mode_map_pkg::BIT_ROM_EN] = 1'b1;
         end
         nxt_ff.rdData = 8'h00;
         nxt_ff.sel = '0;
         nxt_ff.mappedAddr = 16'h0000;
         nxt_ff.pendAddr = 16'h0000;
         nxt_ff.phase = mode_map_pkg::PH_IDLE;
         nxt_ff.pendRd = 1'b0;
         nxt_ff.pendInt = 1'b0;
         nxt_ff.pendOwn = 1'b0;
         nxt_ff.pendWrData = 8'h00;
         nxt_ff.ext = '0;
         nxt_ff.ext.readWrite = 1'b1;
         nxt_ff.eDiv = 2'h0;
         nxt_ff.eClk = 1'b0;
      end else begin
         // Write window counter saturates so it never wraps open
         if (cur_ff.cycleCnt != mode_map_pkg::MAP_WINDOW_CYCLES) begin
            nxt_ff.cycleCnt = cur_ff.cycleCnt + 7'h01;
         end

         // ---------------- Address decode ----------------
         nxt_ff.sel = '0;
         nxt_ff.rdData = 8'h00;
         if (access) begin
            nxt_ff.mappedAddr = effAddr;
            // Fixed priority: registers, RAM, boot ROM, EEPROM, ROM
            if (inRegs) begin
               nxt_ff.sel.hitRegs = 1'b1;
            end else if (inWindow(cpuAddr, cur_ff.ramPos,
                                  mode_map_pkg::RAM_SPAN_MASK)) begin
               nxt_ff.sel.hitRam = 1'b1;
            end else if (cur_ff.bootMap &&
                         effAddr >= mode_map_pkg::BOOT_LO &&
                         effAddr <= mode_map_pkg::BOOT_HI) begin
               nxt_ff.sel.hitBoot = 1'b1;
            end else if (cur_ff.memCfg[mode_map_pkg::BIT_EE_EN] &&
                         effAddr >= mode_map_pkg::EE_LO &&
                         effAddr <= mode_map_pkg::EE_HI) begin
               nxt_ff.sel.hitEeprom = 1'b1;
            end else if (cur_ff.memCfg[mode_map_pkg::BIT_ROM_EN] &&
                         effAddr >= mode_map_pkg::ROM_LO) begin
               nxt_ff.sel.hitRom = 1'b1;
            end else if (cur_ff.modeA) begin
               nxt_ff.sel.hitExt = 1'b1;
            end
         end

         // ---------------- Register reads ----------------
         if (cpuRd && inRegs) begin
            if (ownReg(cpuAddr, mode_map_pkg::ADDR_MODE_PRIO)) begin
               nxt_ff.rdData = {cur_ff.bootMap, cur_ff.specialMode,
                                cur_ff.modeA, cur_ff.rdVisE, cur_ff.psel};
            end else if (ownReg(cpuAddr, mode_map_pkg::ADDR_MAP_POS)) begin
               nxt_ff.rdData = {cur_ff.ramPos, cur_ff.regPos};
            end else if (ownReg(cpuAddr, mode_map_pkg::ADDR_TEST_CTL)) begin
               nxt_ff.rdData = cur_ff.testCtl;
            end else if (ownReg(cpuAddr, mode_map_pkg::ADDR_MEM_CFG)) begin
               nxt_ff.rdData = {4'h0, cur_ff.memCfg};
            end
         end

         // ---------------- Register writes ----------------
         if (cpuWr && inRegs) begin
            if (ownReg(cpuAddr, mode_map_pkg::ADDR_MODE_PRIO)) begin
               // Mode bits move only while the special bit is set
               if (cur_ff.specialMode) begin
                  nxt_ff.bootMap = wd[7];
                  nxt_ff.specialMode = wd[6];
                  nxt_ff.modeA = wd[5];
               end
               if (!cur_ff.rdVisEWritten) begin
                  nxt_ff.rdVisE = wd[4];
                  nxt_ff.rdVisEWritten = 1'b1;
               end
               // Priority select only while interrupts are masked
               if (intMaskSet) begin
                  nxt_ff.psel = wd[3:0];
               end
            end
            if (ownReg(cpuAddr, mode_map_pkg::ADDR_MAP_POS)) begin
               if (cur_ff.specialMode || (!cur_ff.mapWritten &&
                   cur_ff.cycleCnt < mode_map_pkg::MAP_WINDOW_CYCLES))
               begin
                  nxt_ff.ramPos = wd[7:4];
                  nxt_ff.regPos = wd[3:0];
                  nxt_ff.mapWritten = 1'b1;
               end
            end
            if (ownReg(cpuAddr, mode_map_pkg::ADDR_TEST_CTL) &&
                cur_ff.specialMode) begin
               nxt_ff.testCtl = wd & mode_map_pkg::TEST_WR_MASK;
            end
            if (ownReg(cpuAddr, mode_map_pkg::ADDR_MEM_CFG) &&
                cur_ff.specialMode) begin
               nxt_ff.memCfg = wd[3:0];
            end
         end

         // ---------------- Expansion bus ----------------
         // A new access always wins; a cut data phase is the trade for
         // never stalling the processor.
         if (access && cur_ff.modeA) begin
            nxt_ff.phase = mode_map_pkg::PH_ADDR;
            nxt_ff.pendAddr = effAddr;
            nxt_ff.pendRd = cpuRd;
            nxt_ff.pendWrData = wd;
            nxt_ff.pendOwn = inRegs;
            nxt_ff.pendInt = ~nxt_ff.sel.hitExt;
            nxt_ff.ext.portB = effAddr[15:8];
            nxt_ff.ext.portC = effAddr[7:0];
            nxt_ff.ext.portCOe = 1'b1;
            nxt_ff.ext.addrLatchStrobe = 1'b1;
            nxt_ff.ext.readWrite = cpuRd;
         end else if (cur_ff.phase == mode_map_pkg::PH_ADDR) begin
            nxt_ff.phase = mode_map_pkg::PH_DATA;
            nxt_ff.ext.addrLatchStrobe = 1'b0;
            if (!cur_ff.pendRd) begin
               nxt_ff.ext.portC = cur_ff.pendWrData;
               nxt_ff.ext.portCOe = 1'b1;
            end else if (cur_ff.pendInt && cur_ff.rdVisE) begin
               // Internal read data shown outside
               nxt_ff.ext.portC = cur_ff.pendOwn ? cur_ff.rdData
                                                 : intRdData;
               nxt_ff.ext.portCOe = 1'b1;
            end else begin
               nxt_ff.ext.portCOe = 1'b0;
            end
         end else begin
            // Idle or single-chip: no strobe and port C released
            nxt_ff.phase = mode_map_pkg::PH_IDLE;
            nxt_ff.ext.addrLatchStrobe = 1'b0;
            nxt_ff.ext.portCOe = 1'b0;
            nxt_ff.ext.readWrite = 1'b1;
            if (!cur_ff.modeA) begin
               nxt_ff.ext.portB = 8'h00;
               nxt_ff.ext.portC = 8'h00;
            end
         end

         // ---------------- E clock ----------------
         // E runs at a quarter of clk; held low in single-chip once rdVisE is set
         nxt_ff.eDiv = cur_ff.eDiv + 2'h1;
         nxt_ff.eClk = cur_ff.eDiv[1];
         if (!cur_ff.modeA && cur_ff.rdVisE) begin
            nxt_ff.eClk = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      cur_ff <= nxt_ff;
   end

   // Outputs come straight from the state register
   assign cpuRdData = cur_ff.rdData;
   assign memSel = cur_ff.sel;
   assign mappedAddr = cur_ff.mappedAddr;
   assign extBus = cur_ff.ext;
   assign eClkPin = cur_ff.eClk;
   assign bootRomEnable = cur_ff.bootMap;
   assign romEnable = cur_ff.memCfg[mode_map_pkg::BIT_ROM_EN];
   assign eepromEnable = cur_ff.memCfg[mode_map_pkg::BIT_EE_EN];
   assign specialMode = cur_ff.specialMode;
   assign modeA = cur_ff.modeA;
   assign prioSelect = cur_ff.psel;
   assign testCtl = cur_ff.testCtl;
   assign watchdogDisable = cur_ff.memCfg[mode_map_pkg::BIT_NOWD];
   assign securityDisable = cur_ff.memCfg[mode_map_pkg::BIT_SECURITY_DISABLE];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence extAccess;
      access && cur_ff.modeA;
   endsequence

   sequence addrPhase;
      cur_ff.ext.addrLatchStrobe && cur_ff.ext.portCOe;
   endsequence

   sequence visRead;
      cpuRd && cur_ff.modeA && inRegs && cur_ff.rdVisE;
   endsequence

   a_single_no_bus: assert property (
      !cur_ff.modeA ##1 !cur_ff.modeA |->
         !cur_ff.ext.addrLatchStrobe && !cur_ff.ext.portCOe)
      else $error("bus activity in single-chip mode");

   a_addr_phase_out: assert property (
      extAccess |=> addrPhase and
         (cur_ff.ext.portB == $past(effAddr[15:8])) and
         (cur_ff.ext.readWrite == $past(cpuRd)))
      else $error("address phase missing or wrong");

   a_reg_over_ram: assert property (
      access && inRegs |=> cur_ff.sel.hitRegs && !cur_ff.sel.hitRam)
      else $error("register block not given priority");

   a_vector_remap: assert property (
      access && cur_ff.specialMode && cpuAddr >= 16'hFFC0 |=>
         cur_ff.mappedAddr[15:6] == 10'h2FF)
      else $error("vector not moved to bootloader page");

   a_mode_bits_lock: assert property (
      cpuWr && inRegs && !cur_ff.specialMode &&
         ownReg(cpuAddr, mode_map_pkg::ADDR_MODE_PRIO) |=>
         $stable(cur_ff.modeA) && $stable(cur_ff.bootMap) &&
         !cur_ff.specialMode)
      else $error("mode bits changed in a normal mode");

   a_vis_once_only: assert property (
      cur_ff.rdVisEWritten && cpuWr && inRegs |=> $stable(cur_ff.rdVisE))
      else $error("visibility bit took a second write");

   a_vis_data_out: assert property (
      visRead ##1 !access |=> !cur_ff.ext.addrLatchStrobe &&
         cur_ff.ext.portCOe && cur_ff.ext.portC == $past(cur_ff.rdData))
      else $error("internal read not shown on port C");

   a_e_held_low: assert property (
      (!cur_ff.modeA && cur_ff.rdVisE) [*2] |=> !cur_ff.eClk)
      else $error("E clock not held low");

   a_map_window_shut: assert property (
      cpuWr && !cur_ff.specialMode &&
         (cur_ff.mapWritten || cur_ff.cycleCnt >= 7'h40) |=>
         $stable(cur_ff.regPos) && $stable(cur_ff.ramPos))
      else $error("map position written outside its window");

   a_test_reg_lock: assert property (
      !cur_ff.specialMode ##1 !cur_ff.specialMode |->
         $stable(cur_ff.testCtl))
      else $error("factory test register changed in normal mode");

   a_rom_removed: assert property (
      access && !cur_ff.memCfg[mode_map_pkg::BIT_ROM_EN] |=>
         !cur_ff.sel.hitRom)
      else $error("ROM selected while disabled");
endmodule
`default_nettype wire

// File: rtl/mode_map_pkg.sv
`default_nettype none
package mode_map_pkg;
   // ------------------------------------------------------------
   // Register map (low six bits select within the block)
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_MODE_PRIO = 16'h103C;
   localparam logic [15:0] ADDR_MAP_POS = 16'h103D;
   localparam logic [15:0] ADDR_TEST_CTL = 16'h103E;
   localparam logic [15:0] ADDR_MEM_CFG = 16'h103F;
   localparam logic [7:0] MAP_POS_RESET = 8'h01;
   localparam logic [3:0] PSEL_RESET = 4'h5;
   localparam logic [7:0] TEST_WR_MASK = 8'hBF;
   localparam int BIT_DISABLE_RST = 3;
   localparam int BIT_SECURITY_DISABLE = 3;
   localparam int BIT_NOWD = 2;
   localparam int BIT_ROM_EN = 1;
   localparam int BIT_EE_EN = 0;
   // ------------------------------------------------------------
   // Memory map
   // ------------------------------------------------------------
   localparam logic [11:0] REG_SPAN_MASK = 12'h03F;
   localparam logic [11:0] RAM_SPAN_MASK = 12'h1FF;
   localparam logic [15:0] EE_LO = 16'hB600;
   localparam logic [15:0] EE_HI = 16'hB7FF;
   localparam logic [15:0] ROM_LO = 16'hC000;
   localparam logic [15:0] BOOT_LO = 16'hBF40;
   localparam logic [15:0] BOOT_HI = 16'hBFFF;
   localparam logic [15:0] VEC_LO = 16'hFFC0;
   localparam logic [15:0] VEC_ALT_LO = 16'hBFC0;
   // ------------------------------------------------------------
   // Modes {pin B, pin A}, timing
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_SINGLE = 2'h2;
   localparam logic [1:0] MODE_EXPANDED = 2'h3;
   localparam logic [1:0] MODE_BOOT = 2'h0;
   localparam logic [1:0] MODE_TEST = 2'h1;
   localparam logic [6:0] MAP_WINDOW_CYCLES = 7'h40;
   localparam logic [1:0] E_DIV_LAST = 2'h3;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_ADDR = 3'b010,
      PH_DATA = 3'b100
   } busPhase_t;
   typedef struct packed {
      logic hitRegs;
      logic hitRam;
      logic hitBoot;
      logic hitEeprom;
      logic hitRom;
      logic hitExt;
   } memSel_t;
   typedef struct packed {
      logic [7:0] portB;
      logic [7:0] portC;
      logic portCOe;
      logic addrLatchStrobe;
      logic readWrite;
   } extBus_t;
   typedef struct packed {
      logic [1:0] pinS1, pinS2, pinS3, modePins;
      logic bootMap, specialMode, modeA, rdVisE, rdVisEWritten;
      logic [3:0] psel, ramPos, regPos;
      logic mapWritten;
      logic [6:0] cycleCnt;
      logic [7:0] testCtl;
      logic [3:0] memCfg;
      logic [7:0] rdData;
      memSel_t sel;
      logic [15:0] mappedAddr, pendAddr;
      busPhase_t phase;
      logic pendRd, pendInt, pendOwn;
      logic [7:0] pendWrData;
      extBus_t ext;
      logic [1:0] eDiv;
      logic eClk;
   } mapState_t;
endpackage
`default_nettype wire

// File: tb/ext_bus_model.sv
`default_nettype none
module ext_bus_model (
   input wire logic clk,
   input wire mode_map_pkg::extBus_t bus,
   output logic [15:0] latchAddr,
   output logic [7:0] lastData,
   output logic [7:0] strobes
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Demultiplexing latch on the far side
   // ----------------------------------------
   // Known start so counts can be compared by difference
   initial begin
      latchAddr = 16'h0000;
      lastData = 8'h00;
      strobes = 8'h00;
   end
   // Low address is only valid while the strobe is high, so it is caught
   // there; later data on port C must never disturb the latched address
   always @(posedge clk) begin
      if (bus.addrLatchStrobe === 1'b1) begin
         latchAddr <= {bus.portB, bus.portC};
         strobes <= strobes + 8'h01;
      end else if (bus.portCOe === 1'b1) begin
         lastData <= bus.portC;
      end
   end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, modePinA, modePinB, cpuWr, cpuRd, intMaskSet, eClkPin;
   logic bootRomEnable, romEnable, eepromEnable, specialMode, modeA;
   logic watchdogDisable, securityDisable;
   logic [3:0] prioSelect;
   logic [7:0] testCtl;
   logic [15:0] cpuAddr, mappedAddr, latchAddr;
   logic [7:0] cpuWrData, cpuRdData, intRdData, lastData, strobes, n0;
   logic [3:0] nvConfig, ones;
   mode_map_pkg::memSel_t memSel;
   mode_map_pkg::extBus_t extBus;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   mode_and_memory_map_control uut (.clk(clk), .rst_n(rst_n),
      .modePinA(modePinA), .modePinB(modePinB), .cpuAddr(cpuAddr),
      .cpuWrData(cpuWrData), .cpuWr(cpuWr), .cpuRd(cpuRd),
      .cpuRdData(cpuRdData), .intRdData(intRdData),
      .intMaskSet(intMaskSet), .nvConfig(nvConfig), .memSel(memSel),
      .mappedAddr(mappedAddr), .extBus(extBus), .eClkPin(eClkPin),
      .bootRomEnable(bootRomEnable), .romEnable(romEnable),
      .eepromEnable(eepromEnable), .specialMode(specialMode),
      .modeA(modeA), .prioSelect(prioSelect), .testCtl(testCtl),
      .watchdogDisable(watchdogDisable),
      .securityDisable(securityDisable));
   ext_bus_model extMem (.clk(clk), .bus(extBus), .latchAddr(latchAddr),
      .lastData(lastData), .strobes(strobes));
   // ----------------------------------------
   // Clock, hang guard, shared tasks
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Whole run is a few hundred cycles; far past that means a hang
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         $display("BAD t=%0t run did not finish", $time);
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Pins and config settle during the 12-cycle reset
   task automatic do_reset(input logic [1:0] pins, input logic [3:0] nv);
      @(posedge clk);
      rst_n <= 1'b0;
      {modePinB, modePinA} <= pins;
      nvConfig <= nv;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   // One-cycle strobe; returns just after the taking edge
   task automatic acc(input logic rd, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      cpuRd <= rd;
      cpuWr <= ~rd;
      cpuAddr <= a;
      cpuWrData <= d;
      @(posedge clk);
      cpuRd <= 1'b0;
      cpuWr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      acc(1'b1, a, 8'h00);
      chk({8'h00, cpuRdData}, {8'h00, exp});
   endtask
   task automatic sel_chk(input logic [15:0] a, input logic [5:0] exp);
      acc(1'b1, a, 8'h00);
      chk({10'h000, memSel}, {10'h000, exp});
   endtask
   task automatic e_ones();
      ones = 4'h0;
      repeat (8) begin
         @(posedge clk);
         #1;
         ones = ones + {3'h0, eClkPin};
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_single();
      do_reset(mode_map_pkg::MODE_SINGLE, 4'h4);
      n0 = strobes;
      rd_chk(16'h103C, 8'h05);
      rd_chk(16'h103F, 8'h06);
      chk({12'h000, romEnable, eepromEnable, watchdogDisable,
           securityDisable}, 16'h000A);
      // E must run before the visibility bit's one write is spent
      e_ones();
      chk({15'h0000, ones != 4'h0}, 16'h0001);
      acc(1'b0, 16'h103C, 8'hF5);
      rd_chk(16'h103C, 8'h15);
      sel_chk(16'h0000, 6'h10);
      sel_chk(16'h1000, 6'h20);
      sel_chk(16'hC000, 6'h02);
      sel_chk(16'hB600, 6'h00);
      acc(1'b0, 16'h103E, 8'hFF);
      rd_chk(16'h103E, 8'h00);
      acc(1'b0, 16'h103D, 8'h23);
      acc(1'b0, 16'h303D, 8'h45);
      rd_chk(16'h303D, 8'h23);
      sel_chk(16'h2000, 6'h10);
      sel_chk(16'h3000, 6'h20);
      acc(1'b0, 16'h303C, 8'h15);
      acc(1'b0, 16'h303C, 8'h05);
      rd_chk(16'h303C, 8'h15);
      e_ones();
      chk({12'h000, ones}, 16'h0000);
      chk({8'h00, strobes - n0}, 16'h0000);
      $display("single-chip scenario done");
   endtask
   task automatic test_expanded();
      do_reset(mode_map_pkg::MODE_EXPANDED, 4'h1);
      acc(1'b0, 16'h8000, 8'h5A);
      chk({15'h0000, extBus.addrLatchStrobe}, 16'h0001);
      chk({7'h00, extBus.readWrite, extBus.portB}, 16'h0080);
      repeat (2) @(posedge clk);
      #1;
      chk(latchAddr, 16'h8000);
      chk({8'h00, lastData}, 16'h005A);
      sel_chk(16'h0000, 6'h10);
      chk({15'h0000, extBus.addrLatchStrobe}, 16'h0001);
      @(posedge clk);
      #1;
      chk({15'h0000, extBus.portCOe}, 16'h0000);
      sel_chk(16'hB600, 6'h04);
      sel_chk(16'hC000, 6'h01);
      repeat (70) @(posedge clk);
      acc(1'b0, 16'h103D, 8'h23);
      rd_chk(16'h103D, 8'h01);
      $display("expanded scenario done");
   endtask
   task automatic test_boot();
      do_reset(mode_map_pkg::MODE_BOOT, 4'h2);
      rd_chk(16'h103C, 8'hC5);
      chk({13'h0000, bootRomEnable, specialMode, modeA}, 16'h0006);
      rd_chk(16'h103E, 8'h08);
      sel_chk(16'hBF40, 6'h08);
      acc(1'b1, 16'hFFFE, 8'h00);
      chk(mappedAddr, 16'hBFFE);
      acc(1'b0, 16'h103E, 8'hFF);
      rd_chk(16'h103E, 8'hBF);
      acc(1'b0, 16'h103D, 8'hC1);
      sel_chk(16'hC000, 6'h10);
      acc(1'b0, 16'h103D, 8'h00);
      sel_chk(16'h0000, 6'h20);
      acc(1'b0, 16'h003D, 8'h01);
      rd_chk(16'h103D, 8'h01);
      acc(1'b0, 16'h103C, 8'h45);
      sel_chk(16'hBF40, 6'h00);
      chk({14'h0000, bootRomEnable, specialMode}, 16'h0001);
      $display("bootstrap scenario done");
   endtask
   task automatic test_special();
      do_reset(mode_map_pkg::MODE_TEST, 4'h0);
      rd_chk(16'h103C, 8'h75);
      chk({8'h00, testCtl}, 16'h0008);
      acc(1'b1, 16'h0000, 8'h00);
      @(posedge clk);
      #1;
      chk({7'h00, extBus.portCOe, extBus.portC}, 16'h01A5);
      $display("test-mode scenario done");
   endtask
   // Inputs start defined; every scenario then runs in turn
   initial begin
      rst_n <= 1'b0;
      {modePinB, modePinA} <= 2'h2;
      cpuAddr <= 16'h0000;
      cpuWrData <= 8'h00;
      cpuWr <= 1'b0;
      cpuRd <= 1'b0;
      intRdData <= 8'hA5;
      intMaskSet <= 1'b0;
      nvConfig <= 4'h0;
      test_single();
      test_expanded();
      test_boot();
      test_special();
      give_verdict();
   end
endmodule
`default_nettype wire
